// ===== rtl/efac_dev.sv
`timescale 1ns/1ps
`default_nettype none
module efac_dev #(
  parameter int PROG_CYC  = efac_pkg::PROG_CYCLES,
  parameter int ERASE_CYC = efac_pkg::ERASE_CYCLES
) (
  efac_if.dev        ifc,
  output logic       src_isp,
  output logic       ecc_hit
);
  import efac_pkg::*;

  typedef enum {ST_IDLE, ST_PROG, ST_ERASE} efac_st_t;

  // ----------------------------------------
  // ecc helpers
  // ----------------------------------------
  function automatic logic [ECC_W-1:0] ecc_gen(input logic [7:0] d);
    return {^d[7:4], ^{d[7], d[3:1]}, ^{d[6:5], d[3:2], d[0]}, ^{d[6], d[4:3], d[1:0]}};
  endfunction

  // syndrome is the hamming position of the bad bit; check-bit hits need no fix
  function automatic logic [7:0] ecc_flip(input logic [ECC_W-1:0] s);
    case (s)
      4'h3:    return 8'h01;
      4'h5:    return 8'h02;
      4'h6:    return 8'h04;
      4'h7:    return 8'h08;
      4'h9:    return 8'h10;
      4'ha:    return 8'h20;
      4'hb:    return 8'h40;
      4'hc:    return 8'h80;
      default: return 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0]          mem_r   [ARRAY_BYTES];
  logic [ECC_W-1:0]    chk_r   [ARRAY_BYTES];
  logic [1:0]          wlcnt_r [NUM_WL];
  logic [7:0]          wlbuf_r [WL_BYTES];

  efac_st_t            state_r;
  efac_st_t            state_nxt;
  logic [TMR_W-1:0]    tmr_r;
  logic [TMR_W-1:0]    tmr_nxt;
  logic [WL_AW-1:0]    pwl_r;
  logic [NUM_SECT-1:0] emask_r;
  logic [1:0]          rcnt_r;
  logic [AW-1:0]       raddr_r;
  logic                rd_valid_r;
  logic [7:0]          rd_data_r;
  logic                rd_fixed_r;
  logic                ack_r;
  logic                err_r;
  logic                busy_r;
  logic                done_r;
  logic                aborted_r;
  logic                src_isp_r;
  logic                ecc_hit_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire                 idle      = (state_r == ST_IDLE);
  wire                 tmr_end   = !idle && (tmr_r == '0);
  wire                 prog_fin  = (state_r == ST_PROG) && tmr_end;
  wire                 erase_fin = (state_r == ST_ERASE) && tmr_end;
  wire [WL_AW-1:0]     cmd_wl    = ifc.cmd_addr[AW-1:WLW];
  wire                 is_prog   = ifc.cmd_req && (ifc.cmd_op == EFAC_OP_PROG);
  wire                 is_erase  = ifc.cmd_req && (ifc.cmd_op == EFAC_OP_ERASE);
  wire                 is_abort  = ifc.cmd_req && (ifc.cmd_op == EFAC_OP_ABORT);
  wire                 wl_room   = wlcnt_r[cmd_wl] < efac_wl_max(ifc.cmd_addr);
  wire                 prog_go   = is_prog && idle && wl_room;
  wire                 erase_go  = is_erase && idle && (|ifc.cmd_sect);
  // abort only a running erase; a finishing erase wins the tie
  wire                 abort_go  = is_abort && (state_r == ST_ERASE) && !tmr_end;
  wire                 cmd_ok    = prog_go || erase_go || abort_go;
  // reads stay open during program and erase, so the cpu is never held
  wire                 rd_take   = ifc.rd_req && (rcnt_r <= 2'h1);
  wire [7:0]           rd_raw    = mem_r[raddr_r];
  wire [ECC_W-1:0]     rd_syn    = chk_r[raddr_r] ^ ecc_gen(rd_raw);
  wire [7:0]           rd_flip   = ecc_flip(rd_syn);

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  // background program and erase
  always_comb begin
    state_nxt = state_r;
    tmr_nxt   = (tmr_r == '0) ? tmr_r : tmr_r - 1'b1;
    unique case (state_r)
      ST_IDLE: begin
        if (prog_go) begin
          state_nxt = ST_PROG;
          tmr_nxt   = TMR_W'(PROG_CYC - 1);
        end else if (erase_go) begin
          state_nxt = ST_ERASE;
          tmr_nxt   = TMR_W'(ERASE_CYC - 1);
        end
      end
      ST_PROG: begin
        if (tmr_end) begin
          state_nxt = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (tmr_end || abort_go) begin
          state_nxt = ST_IDLE;
          tmr_nxt   = '0;
        end
      end
    endcase
  end

  always_ff @(posedge ifc.clk or negedge ifc.reset_n) begin
    if (!ifc.reset_n) begin
      state_r <= ST_IDLE;
      tmr_r   <= '0;
      pwl_r   <= '0;
      emask_r <= '0;
    end else begin
      state_r <= state_nxt;
      tmr_r   <= tmr_nxt;
      if (prog_go) begin
        pwl_r <= cmd_wl;
      end
      // several sectors may share one erase
      if (erase_go) begin
        emask_r <= ifc.cmd_sect;
      end
    end
  end

  // ----------------------------------------
  // command answers
  // ----------------------------------------
  always_ff @(posedge ifc.clk or negedge ifc.reset_n) begin
    if (!ifc.reset_n) begin
      ack_r     <= 1'b0;
      err_r     <= 1'b0;
      busy_r    <= 1'b0;
      done_r    <= 1'b0;
      aborted_r <= 1'b0;
      src_isp_r <= 1'b0;
    end else begin
      ack_r     <= ifc.cmd_req;
      err_r     <= ifc.cmd_req && !cmd_ok;
      busy_r    <= (state_nxt != ST_IDLE);
      done_r    <= tmr_end || abort_go;
      aborted_r <= abort_go;
      if (prog_go || erase_go) begin
        src_isp_r <= ifc.cmd_isp;
      end
    end
  end

  // ----------------------------------------
  // read path
  // ----------------------------------------
  always_ff @(posedge ifc.clk or negedge ifc.reset_n) begin
    if (!ifc.reset_n) begin
      rcnt_r     <= '0;
      raddr_r    <= '0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
      rd_fixed_r <= 1'b0;
      ecc_hit_r  <= 1'b0;
    end else begin
      // byte answer three clocks after request
      if (rd_take) begin
        rcnt_r  <= READ_CYCLES;
        raddr_r <= ifc.rd_addr;
      end else if (rcnt_r != '0) begin
        rcnt_r <= rcnt_r - 1'b1;
      end
      rd_valid_r <= (rcnt_r == 2'h1);
      ecc_hit_r  <= (rcnt_r == 2'h1) && (rd_flip != '0);
      if (rcnt_r == 2'h1) begin
        rd_data_r  <= rd_raw ^ rd_flip;
        rd_fixed_r <= (rd_flip != '0);
      end
    end
  end

  // ----------------------------------------
  // array (non-volatile, so no reset)
  // ----------------------------------------
  // delivered erased, all zeros
  initial begin
    for (int i = 0; i < ARRAY_BYTES; i++) begin
      mem_r[i] = '0;
      chk_r[i] = '0;
    end
    for (int w = 0; w < NUM_WL; w++) begin
      wlcnt_r[w] = '0;
    end
  end

  // buffer is locked while its program runs
  always_ff @(posedge ifc.clk) begin
    if (ifc.ld_req && (state_r != ST_PROG)) begin
      wlbuf_r[ifc.ld_idx] <= ifc.ld_data;
    end
  end

  always @(posedge ifc.clk) begin
    if (prog_fin) begin
      for (int i = 0; i < WL_BYTES; i++) begin
        mem_r[{pwl_r, WLW'(i)}] <= mem_r[{pwl_r, WLW'(i)}] | wlbuf_r[i];
        chk_r[{pwl_r, WLW'(i)}] <= ecc_gen(mem_r[{pwl_r, WLW'(i)}] | wlbuf_r[i]);
      end
      wlcnt_r[pwl_r] <= wlcnt_r[pwl_r] + 2'h1;
    end
    if (erase_fin) begin
      // whole sectors only; erased to zero
      for (int i = 0; i < ARRAY_BYTES; i++) begin
        if (emask_r[efac_sector(AW'(i))]) begin
          mem_r[i] <= '0;
          chk_r[i] <= '0;
        end
      end
      // data bank maps to finer sectors
      for (int w = 0; w < NUM_WL; w++) begin
        if (emask_r[efac_sector({WL_AW'(w), 5'h00})]) begin
          wlcnt_r[w] <= '0;
        end
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // bank count and data-bank index fixed in package
  assign ifc.rd_valid = rd_valid_r;
  assign ifc.rd_data  = rd_data_r;
  assign ifc.rd_fixed = rd_fixed_r;
  assign ifc.cmd_ack  = ack_r;
  assign ifc.cmd_err  = err_r;
  assign ifc.busy     = busy_r;
  assign ifc.done     = done_r;
  assign ifc.aborted  = aborted_r;
  assign src_isp      = src_isp_r;
  assign ecc_hit      = ecc_hit_r;
endmodule
`default_nettype wire

// ===== rtl/efac_pkg.sv
// What this block does
// - ecc corrects single-bit errors on each read
// - program and erase run in background
// - erase in progress can be aborted early
// - program covers one whole 32-byte wordline
// - erase whole sectors, one or several together
// - single-byte reads complete in three clocks
// - erased cells read back as zero
// - program and erase timed by clock counts
// - program-bank wordline programmed once before erase
// - requester erases whole sector to clear wordline
// - data-bank wordline programmed at most twice
// - second data-bank program writes zeros over old
// - four banks of 4 Kbytes
// - one data bank, rest are program banks
// - data bank has more, smaller sectors
// - accepts in-system and in-application programming requests
package efac_pkg;
  localparam int NUM_BANKS   = 4;
  localparam int BANK_BYTES  = 4096;
  localparam int ARRAY_BYTES = NUM_BANKS * BANK_BYTES;
  localparam int AW          = 14;
  localparam int WL_BYTES    = 32;
  localparam int WLW         = 5;
  localparam int NUM_WL      = ARRAY_BYTES / WL_BYTES;
  localparam int WL_AW       = 9;
  localparam int NUM_SECT    = 20;
  localparam int ECC_W       = 4;
  localparam int TMR_W       = 23;
  localparam int PROG_CYCLES  = 209440;
  localparam int ERASE_CYCLES = 8175360;
  localparam logic [1:0] READ_CYCLES    = 2'h3;
  localparam logic [1:0] DATA_BANK      = 2'h3;
  localparam logic [4:0] DSECT_BASE     = 5'h0c;
  localparam logic [1:0] PBANK_PROG_MAX = 2'h1;
  localparam logic [1:0] DBANK_PROG_MAX = 2'h2;

  typedef enum logic [1:0] {EFAC_OP_PROG, EFAC_OP_ERASE, EFAC_OP_ABORT} efac_op_t;

  // program banks: 4 sectors of 1 Kbyte; data bank: 8 sectors of 512 bytes
  function automatic logic [4:0] efac_sector(input logic [AW-1:0] a);
    if (a[13:12] == DATA_BANK) begin
      return DSECT_BASE + {2'h0, a[11:9]};
    end
    return {1'b0, a[13:12], a[11:10]};
  endfunction

  function automatic logic [1:0] efac_wl_max(input logic [AW-1:0] a);
    return (a[13:12] == DATA_BANK) ? DBANK_PROG_MAX : PBANK_PROG_MAX;
  endfunction
endpackage

// ===== rtl/efac_if.sv
`timescale 1ns/1ps
`default_nettype none
interface efac_if (
  input wire logic clk,
  input wire logic reset_n
);
  import efac_pkg::*;
  logic                rd_req;
  logic [AW-1:0]       rd_addr;
  logic                rd_valid;
  logic [7:0]          rd_data;
  logic                rd_fixed;
  logic                ld_req;
  logic [WLW-1:0]      ld_idx;
  logic [7:0]          ld_data;
  logic                cmd_req;
  efac_op_t            cmd_op;
  logic [AW-1:0]       cmd_addr;
  logic [NUM_SECT-1:0] cmd_sect;
  logic                cmd_isp;
  logic                cmd_ack;
  logic                cmd_err;
  logic                busy;
  logic                done;
  logic                aborted;

  modport dev (
    input  clk, reset_n, rd_req, rd_addr, ld_req, ld_idx, ld_data,
    input  cmd_req, cmd_op, cmd_addr, cmd_sect, cmd_isp,
    output rd_valid, rd_data, rd_fixed, cmd_ack, cmd_err, busy, done, aborted
  );
  modport host (
    input  clk, reset_n, rd_valid, rd_data, rd_fixed, cmd_ack, cmd_err, busy, done, aborted,
    output rd_req, rd_addr, ld_req, ld_idx, ld_data,
    output cmd_req, cmd_op, cmd_addr, cmd_sect, cmd_isp
  );
endinterface
`default_nettype wire

// ===== rtl/efac_host.sv
`timescale 1ns/1ps
`default_nettype none
module efac_host (
  efac_if.host                           ifc,
  input  wire logic                      u_rd_req,
  input  wire logic [efac_pkg::AW-1:0]   u_rd_addr,
  output logic                           u_rd_valid,
  output logic [7:0]                     u_rd_data,
  output logic                           u_rd_fixed,
  input  wire logic                      u_prog_req,
  input  wire logic [efac_pkg::AW-1:0]   u_prog_addr,
  input  wire logic [255:0]              u_prog_data,
  input  wire logic [31:0]               u_prog_ben,
  input  wire logic                      u_erase_req,
  input  wire logic [efac_pkg::NUM_SECT-1:0] u_erase_sect,
  input  wire logic                      u_abort_req,
  input  wire logic                      u_isp,
  output logic                           u_ready,
  output logic                           u_done,
  output logic                           u_aborted,
  output logic                           u_err
);
  import efac_pkg::*;

  typedef enum {H_IDLE, H_LOAD, H_CMD, H_ACK} efac_hst_t;

  efac_hst_t           st_r;
  logic [1:0]          hcnt_r [NUM_WL];
  logic [255:0]        pbuf_r;
  logic [WLW-1:0]      lcnt_r;
  logic                pend_prog_r;
  logic [WL_AW-1:0]    pend_wl_r;
  logic [NUM_SECT-1:0] pend_sect_r;
  efac_op_t            op_r;
  logic                isp_r;
  logic                rd_req_r;
  logic [AW-1:0]       rd_addr_r;
  logic                ld_req_r;
  logic [WLW-1:0]      ld_idx_r;
  logic [7:0]          ld_data_r;
  logic                cmd_req_r;
  logic                rd_valid_r;
  logic [7:0]          rd_data_r;
  logic                rd_fixed_r;
  logic                ready_r;
  logic                done_r;
  logic                aborted_r;
  logic                err_r;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire                 idle_ok  = (st_r == H_IDLE) && !ifc.busy;
  wire [WL_AW-1:0]     u_wl     = u_prog_addr[AW-1:WLW];
  // never exceed the wordline program limit
  wire                 wl_room  = hcnt_r[u_wl] < efac_wl_max(u_prog_addr);
  wire                 take_ab  = (st_r == H_IDLE) && u_abort_req;
  wire                 take_pg  = idle_ok && !u_abort_req && u_prog_req;
  wire                 take_er  = idle_ok && !u_abort_req && !u_prog_req && u_erase_req;
  wire                 fin_ok   = ifc.done && !ifc.aborted;
  logic [255:0]        masked;

  // unselected bytes go as zeros, keeping earlier content
  always_comb begin
    masked = '0;
    for (int i = 0; i < WL_BYTES; i++) begin
      masked[i*8 +: 8] = u_prog_ben[i] ? u_prog_data[i*8 +: 8] : 8'h00;
    end
  end

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge ifc.clk or negedge ifc.reset_n) begin
    if (!ifc.reset_n) begin
      st_r      <= H_IDLE;
      op_r      <= EFAC_OP_PROG;
      isp_r     <= 1'b0;
      pbuf_r    <= '0;
      lcnt_r    <= '0;
      cmd_req_r <= 1'b0;
      ld_req_r  <= 1'b0;
      ld_idx_r  <= '0;
      ld_data_r <= '0;
      err_r     <= 1'b0;
    end else begin
      cmd_req_r <= (st_r == H_CMD);
      ld_req_r  <= (st_r == H_LOAD);
      err_r     <= (take_pg && !wl_room) || ((st_r == H_ACK) && ifc.cmd_ack && ifc.cmd_err);
      unique case (st_r)
        H_IDLE: begin
          isp_r <= u_isp;
          if (take_ab) begin
            op_r <= EFAC_OP_ABORT;
            st_r <= H_CMD;
          end else if (take_pg && wl_room) begin
            op_r   <= EFAC_OP_PROG;
            pbuf_r <= masked;
            lcnt_r <= '0;
            st_r   <= H_LOAD;
          end else if (take_er) begin
            op_r <= EFAC_OP_ERASE;
            st_r <= H_CMD;
          end
        end
        H_LOAD: begin
          ld_idx_r  <= lcnt_r;
          ld_data_r <= pbuf_r[lcnt_r*8 +: 8];
          lcnt_r    <= lcnt_r + 1'b1;
          if (lcnt_r == WLW'(WL_BYTES - 1)) begin
            st_r <= H_CMD;
          end
        end
        H_CMD: begin
          st_r <= H_ACK;
        end
        H_ACK: begin
          if (ifc.cmd_ack) begin
            st_r <= H_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // wordline program tracking
  // ----------------------------------------
  always_ff @(posedge ifc.clk or negedge ifc.reset_n) begin
    if (!ifc.reset_n) begin
      pend_prog_r <= 1'b0;
      pend_wl_r   <= '0;
      pend_sect_r <= '0;
      for (int w = 0; w < NUM_WL; w++) begin
        hcnt_r[w] <= '0;
      end
    end else begin
      if (take_pg && wl_room) begin
        pend_prog_r <= 1'b1;
        pend_wl_r   <= u_wl;
      end else if (take_er) begin
        pend_prog_r <= 1'b0;
        pend_sect_r <= u_erase_sect;
      end
      if (fin_ok && pend_prog_r) begin
        hcnt_r[pend_wl_r] <= hcnt_r[pend_wl_r] + 2'h1;
      end else if (fin_ok) begin
        for (int w = 0; w < NUM_WL; w++) begin
          if (pend_sect_r[efac_sector({WL_AW'(w), 5'h00})]) begin
            hcnt_r[w] <= '0;
          end
        end
      end
    end
  end

  // ----------------------------------------
  // read pass-through and status
  // ----------------------------------------
  always_ff @(posedge ifc.clk or negedge ifc.reset_n) begin
    if (!ifc.reset_n) begin
      rd_req_r   <= 1'b0;
      rd_addr_r  <= '0;
      rd_valid_r <= 1'b0;
      rd_data_r  <= '0;
      rd_fixed_r <= 1'b0;
      ready_r    <= 1'b0;
      done_r     <= 1'b0;
      aborted_r  <= 1'b0;
    end else begin
      rd_req_r   <= u_rd_req;
      rd_addr_r  <= u_rd_addr;
      rd_valid_r <= ifc.rd_valid;
      rd_data_r  <= ifc.rd_data;
      rd_fixed_r <= ifc.rd_fixed;
      ready_r    <= idle_ok;
      done_r     <= ifc.done;
      aborted_r  <= ifc.aborted;
    end
  end

  assign ifc.rd_req   = rd_req_r;
  assign ifc.rd_addr  = rd_addr_r;
  assign ifc.ld_req   = ld_req_r;
  assign ifc.ld_idx   = ld_idx_r;
  assign ifc.ld_data  = ld_data_r;
  assign ifc.cmd_req  = cmd_req_r;
  assign ifc.cmd_op   = op_r;
  assign ifc.cmd_addr = {pend_wl_r, 5'h00};
  assign ifc.cmd_sect = pend_sect_r;
  assign ifc.cmd_isp  = isp_r;
  assign u_rd_valid   = rd_valid_r;
  assign u_rd_data    = rd_data_r;
  assign u_rd_fixed   = rd_fixed_r;
  assign u_ready      = ready_r;
  assign u_done       = done_r;
  assign u_aborted    = aborted_r;
  assign u_err        = err_r;
endmodule
`default_nettype wire

// ===== verif/efac_properties.sv
`timescale 1ns/1ps
`default_nettype none
module efac_properties
  import efac_pkg::*;
#(
  parameter int PROG_CYC  = 20,
  parameter int ERASE_CYC = 50
) (
  input wire logic     clk,
  input wire logic     reset_n,
  input wire logic     rd_req,
  input wire logic     rd_valid,
  input wire logic     cmd_req,
  input wire efac_op_t cmd_op,
  input wire logic     cmd_ack,
  input wire logic     cmd_err,
  input wire logic     busy,
  input wire logic     done,
  input wire logic     aborted
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----------
  // run length
  // ----------
  efac_op_t    op_r;
  logic [23:0] cnt_r;
  wire         start = cmd_req && !busy && cmd_op != EFAC_OP_ABORT;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      op_r  <= EFAC_OP_PROG;
      cnt_r <= 24'h0;
    end else begin
      cnt_r <= busy ? cnt_r + 24'h1 : 24'h0;
      if (start) begin
        op_r <= cmd_op;
      end
    end
  end
  // ----------
  // properties
  // ----------
  property p_rd_lat; rd_req && !$past(rd_req) && !$past(rd_req, 2) |-> ##4 rd_valid; endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("read answer late");
  property p_rd_cause; rd_valid |-> $past(rd_req, 4); endproperty
  a_rd_cause: assert property (p_rd_cause)
    else $error("read answer without request");
  property p_ack; cmd_req |=> cmd_ack; endproperty
  a_ack: assert property (p_ack)
    else $error("command not acknowledged");
  property p_abort_idle; cmd_req && cmd_op == EFAC_OP_ABORT && !busy |=> cmd_err; endproperty
  a_abort_idle: assert property (p_abort_idle)
    else $error("idle abort not refused");
  property p_abort_run; cmd_req && cmd_op == EFAC_OP_ABORT && busy |=> cmd_ack && (cmd_err ^ aborted); endproperty
  a_abort_run: assert property (p_abort_run)
    else $error("abort outcome wrong");
  property p_done; done |-> !busy && $past(busy); endproperty
  a_done: assert property (p_done)
    else $error("done without busy end");
  property p_aborted; aborted |-> done; endproperty
  a_aborted: assert property (p_aborted)
    else $error("aborted without done");
  property p_busy_rise; cmd_ack && !cmd_err && $past(cmd_op) != EFAC_OP_ABORT |-> busy; endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy missing after accept");
  property p_time;
    done && !aborted |-> cnt_r == ((op_r == EFAC_OP_ERASE) ? 24'(ERASE_CYC) : 24'(PROG_CYC));
  endproperty
  a_time: assert property (p_time)
    else $error("operation length wrong");
endmodule
`default_nettype wire

// ===== verif/embedded_flash_array_control_bench.sv
`timescale 1ns/1ps
`default_nettype none
module embedded_flash_array_control_bench;
  import efac_pkg::*;
  localparam int PC = 20;
  localparam int EC = 50;
  logic          clk          = '0;
  logic          reset_n      = '0;
  logic          u_rd_req     = '0;
  logic [AW-1:0] u_rd_addr    = '0;
  logic          u_prog_req   = '0;
  logic [AW-1:0] u_prog_addr  = '0;
  logic [255:0]  u_prog_data  = '0;
  logic [31:0]   u_prog_ben   = '0;
  logic          u_erase_req  = '0;
  logic [19:0]   u_erase_sect = '0;
  logic          u_abort_req  = '0;
  logic          u_isp        = '0;
  logic          u_rd_valid, u_rd_fixed, u_ready, u_done, u_aborted, u_err, src_isp, ecc_hit;
  logic [7:0]    u_rd_data;
  logic [7:0]    mem [ARRAY_BYTES];
  int            cnt [NUM_WL];
  logic          fix          = '0;
  int            err_count, comparisons, cyc;
  // ---------
  // structure
  // ---------
  efac_if ifc (.clk(clk), .reset_n(reset_n));
  efac_dev #(.PROG_CYC(PC), .ERASE_CYC(EC)) efac_dev_i (.ifc(ifc.dev), .src_isp(src_isp), .ecc_hit(ecc_hit));
  efac_host efac_host_i (.ifc(ifc.host), .u_rd_req(u_rd_req), .u_rd_addr(u_rd_addr), .u_rd_valid(u_rd_valid),
    .u_rd_data(u_rd_data), .u_rd_fixed(u_rd_fixed), .u_prog_req(u_prog_req), .u_prog_addr(u_prog_addr),
    .u_prog_data(u_prog_data), .u_prog_ben(u_prog_ben), .u_erase_req(u_erase_req), .u_erase_sect(u_erase_sect),
    .u_abort_req(u_abort_req), .u_isp(u_isp), .u_ready(u_ready), .u_done(u_done), .u_aborted(u_aborted),
    .u_err(u_err));
  efac_properties #(.PROG_CYC(PC), .ERASE_CYC(EC)) efac_properties_i (.clk(clk), .reset_n(reset_n),
    .rd_req(ifc.rd_req), .rd_valid(ifc.rd_valid), .cmd_req(ifc.cmd_req), .cmd_op(ifc.cmd_op),
    .cmd_ack(ifc.cmd_ack), .cmd_err(ifc.cmd_err), .busy(ifc.busy), .done(ifc.done), .aborted(ifc.aborted));
  always #4 clk = ~clk;
  // a hang still reaches the closing report
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      end_sim();
    end
  end
  // ecc pulse must ride with the device's read answer
  always @(negedge clk) begin
    if (ifc.rd_valid === 1'h1) begin
      chk(32'(ecc_hit), 32'(fix));
    end
  end
  // -----
  // tasks
  // -----
  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  function automatic int sect_of(input int a);
    return (a >> 12) == 3 ? 12 + ((a >> 9) & 7) : a >> 10;
  endfunction
  task automatic rd(input int a);
    int i;
    @(negedge clk);
    u_rd_req  = 1'h1;
    u_rd_addr = AW'(a);
    @(negedge clk);
    u_rd_req = 1'h0;
    for (i = 0; i < 8 && u_rd_valid !== 1'h1; i++)
      @(negedge clk);
    chk(32'({u_rd_valid, u_rd_fixed, u_rd_data}), 32'({1'h1, fix, mem[a]}));
  endtask
  task automatic go(input int k, input int a, input logic [19:0] s);
    @(negedge clk);
    u_prog_addr  = AW'(a);
    u_erase_sect = s;
    u_prog_req   = k == 0;
    u_erase_req  = k == 1;
    u_abort_req  = k == 2;
    @(negedge clk);
    {u_prog_req, u_erase_req, u_abort_req} = 3'h0;
  endtask
  task automatic fin(input logic e, input logic ab);
    int i;
    for (i = 0; i < 400 && u_done !== 1'h1 && u_err !== 1'h1; i++)
      @(negedge clk);
    chk(32'({u_err, u_aborted}), 32'({e, ab}));
  endtask
  // model: programming ors bytes in, counts grow per wordline
  task automatic prog(input int a);
    int   i;
    int   w;
    logic e;
    w = a >> 5;
    e = cnt[w] >= ((a >> 12) == 3 ? 2 : 1);
    go(0, a, '0);
    fin(e, 1'h0);
    if (!e) begin
      cnt[w]++;
      for (i = 0; i < WL_BYTES; i++)
        if (u_prog_ben[i]) mem[w * 32 + i] |= u_prog_data[8 * i +: 8];
    end
  endtask
  task automatic erase(input logic [19:0] s, input int ra);
    int a;
    go(1, 0, s);
    if (ra >= 0) begin
      rd(ra);
      chk(32'(u_ready), 32'h0);
    end
    fin(s == '0, 1'h0);
    for (a = 0; a < ARRAY_BYTES; a++)
      if (s[sect_of(a)]) begin
        mem[a] = 8'h00;
        cnt[a >> 5] = 0;
      end
  endtask
  // --------
  // sequence
  // --------
  initial begin
    int i;
    void'($urandom(32'h66e3338f));
    foreach (mem[j]) mem[j] = 8'h00;
    repeat (3) @(negedge clk);
    reset_n = 1'h1;
    for (i = 0; i < 6; i++) rd(int'($urandom % ARRAY_BYTES));
    rd(32'h3fff);
    for (i = 0; i < 8; i++) u_prog_data[32 * i +: 32] = $urandom;
    u_prog_ben = '1;
    prog(32'h0440);
    prog(32'h0000);
    rd(32'h0440);
    rd(32'h045f);
    prog(32'h0440);
    u_isp = 1'h1;
    u_prog_ben = 32'h0000ffff;
    prog(32'h3a20);
    u_prog_ben = 32'hffff0000;
    prog(32'h3a20);
    rd(32'h3a23);
    rd(32'h3a34);
    prog(32'h3a20);
    chk(32'(src_isp), 32'h1);
    u_isp = 1'h0;
    erase(20'h00000, -1);
    erase(20'h20002, 32'h0440);
    chk(32'(src_isp), 32'h0);
    rd(32'h0440);
    rd(32'h3a20);
    rd(32'h0000);
    prog(32'h0440);
    go(1, 0, 20'h00001);
    repeat (10) @(negedge clk);
    go(2, 0, '0);
    fin(1'h0, 1'h1);
    rd(32'h0000);
    go(2, 0, '0);
    fin(1'h1, 1'h0);
    // a single flipped data bit must come back corrected and flagged
    @(negedge clk);
    efac_dev_i.mem_r[32'h0001] = efac_dev_i.mem_r[32'h0001] ^ 8'h10;
    fix = 1'h1;
    rd(32'h0001);
    chk(32'(u_ready), 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
